// ### src/mbs_fill.sv
// Read word selection with fill values for unmapped and reserved registers
`timescale 1ns/100ps
`default_nettype none
module mbs_fill (
    input  wire mbs_pkg::mbs_map_rsp_t i_rsp,
    output logic [15:0]                o_word
);
    always_comb begin
        if (!i_rsp.mapped) begin
            o_word = mbs_pkg::FILL_UNMAPPED;
        end else if (!i_rsp.reserved) begin
            o_word = i_rsp.rdata;
        end else begin
            // Word index 0 is the upper word of a multi-word value
            case (i_rsp.fmt)
                mbs_pkg::FMT_S16: o_word = mbs_pkg::FILL_SIGN;
                mbs_pkg::FMT_S32,
                mbs_pkg::FMT_S64: o_word = (i_rsp.word_idx == 2'h0) ? mbs_pkg::FILL_SIGN : mbs_pkg::FILL_ZERO;
                mbs_pkg::FMT_F32: o_word = (i_rsp.word_idx == 2'h0) ? mbs_pkg::FILL_QNAN_HI : mbs_pkg::FILL_ZERO;
                default:          o_word = mbs_pkg::FILL_ONES;
            endcase
        end
    end
endmodule : mbs_fill
`default_nettype wire

// ### src/mbs_pkg.sv
// Shared constants and carrier types of the Modbus server request handler
package mbs_pkg;
    localparam logic [7:0]  FC_RD_COIL    = 8'h01;
    localparam logic [7:0]  FC_RD_DISC    = 8'h02;
    localparam logic [7:0]  FC_RD_HOLD    = 8'h03;
    localparam logic [7:0]  FC_RD_INP     = 8'h04;
    localparam logic [7:0]  FC_WR_REG     = 8'h06;
    localparam logic [7:0]  FC_WR_REGS    = 8'h10;
    localparam logic [7:0]  FC_REPORT_ID  = 8'h11;
    localparam logic [7:0]  FC_DEV_ID     = 8'h2B;
    localparam logic [7:0]  FC_RD_SCAT    = 8'h64;
    localparam logic [7:0]  MEI_DEV_ID    = 8'h0E;
    localparam logic [7:0]  UNIT_BCAST    = 8'h00;
    localparam logic [7:0]  UNIT_SINGLE   = 8'hF8;
    localparam logic [7:0]  EXC_FUNC      = 8'h01;
    localparam logic [7:0]  EXC_ADDR      = 8'h02;
    localparam logic [7:0]  EXC_VALUE     = 8'h03;
    localparam logic [7:0]  EXC_FLAG      = 8'h80;
    localparam logic [7:0]  RUN_ON        = 8'hFF;
    localparam logic [7:0]  DEVID_CONFORM = 8'h01;
    localparam logic [15:0] FILL_UNMAPPED = 16'h8000;
    localparam logic [15:0] FILL_SIGN     = 16'h8000;
    localparam logic [15:0] FILL_ONES     = 16'hFFFF;
    localparam logic [15:0] FILL_ZERO     = 16'h0000;
    localparam logic [15:0] FILL_QNAN_HI  = 16'hFFC0;
    localparam logic [10:0] MAX_BITS      = 11'h7D0;
    localparam logic [10:0] MAX_RD_REGS   = 11'h07D;
    localparam logic [10:0] MAX_WR_REGS   = 11'h07B;

    typedef enum logic [2:0] {
        ST_RX    = 3'b000,
        ST_DEC   = 3'b001,
        ST_CHECK = 3'b011,
        ST_HDR   = 3'b010,
        ST_EXEC  = 3'b110,
        ST_FLUSH = 3'b111
    } mbs_state_t;

    typedef enum logic [1:0] {CLS_COIL, CLS_DISC, CLS_HOLD, CLS_INP} mbs_class_t;
    typedef enum logic [1:0] {OP_PROBE, OP_READ, OP_WRITE} mbs_op_t;
    typedef enum logic [2:0] {FMT_U16, FMT_S16, FMT_U32, FMT_S32, FMT_S64, FMT_F32} mbs_fmt_t;

    typedef struct packed {
        logic        req;
        mbs_op_t     op;
        mbs_class_t  cls;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mbs_map_req_t;

    typedef struct packed {
        logic        ack;
        logic        mapped;
        logic        reserved;
        logic        addr_ok;
        logic        secured;
        logic        read_only;
        logic        partial;
        logic        value_ok;
        mbs_fmt_t    fmt;
        logic [1:0]  word_idx;
        logic [15:0] rdata;
    } mbs_map_rsp_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
    } mbs_byte_t;
endpackage : mbs_pkg

// ### src/mbs_server.sv
// Modbus server request handler: decode, checks, register access and reply bytes
`timescale 1ns/100ps
`default_nettype none
module mbs_server #(
    parameter int         BUF_DEPTH   = 256,
    parameter logic [7:0] SERVER_ID   = 8'h5A, // Arbitrary identity value
    parameter logic [7:0] DEVID_VALUE = 8'h41  // Arbitrary identity value
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rstn,
    input  wire logic [7:0]            i_unit_id,
    input  wire logic                  i_serial,
    input  wire logic                  i_single_server,
    input  wire logic                  i_rx_valid,
    input  wire logic [7:0]            i_rx_data,
    input  wire logic                  i_rx_last,
    output logic                       o_rx_ready,
    output mbs_pkg::mbs_map_req_t      o_map,
    input  wire mbs_pkg::mbs_map_rsp_t i_map,
    output mbs_pkg::mbs_byte_t         o_tx,
    input  wire logic                  i_tx_ready,
    input  wire logic                  i_cli_valid,
    input  wire logic [15:0]           i_cli_first,
    input  wire logic [15:0]           i_cli_second,
    input  wire logic                  i_cli_low_first,
    output logic                       o_cli_valid,
    output logic [31:0]                o_cli_value
);
    localparam int AW = $clog2(BUF_DEPTH);

    if (BUF_DEPTH < 16 || BUF_DEPTH > 256) begin : g_depth_check
        $error("BUF_DEPTH must lie in 16..256");
    end

    typedef struct packed {
        mbs_pkg::mbs_state_t   state;
        logic [8:0]            len;
        logic                  ovf;
        logic                  rdy;
        logic [7:0]            fc;
        mbs_pkg::mbs_class_t   cls;
        logic                  bits;
        logic                  wr;
        logic                  bcast;
        logic [7:0]            exc;
        logic [15:0]           addr;
        logic [10:0]           qty;
        logic [10:0]           idx;
        logic                  pend;
        mbs_pkg::mbs_map_req_t map;
        mbs_pkg::mbs_byte_t    tx;
        logic                  lo_pend;
        logic                  lo_last;
        logic [7:0]            lo_byte;
        logic [7:0]            acc;
        logic [3:0]            hidx;
    } mbs_srv_st_t;

    mbs_srv_st_t s;
    mbs_srv_st_t n;
    logic [7:0]  buf_q [BUF_DEPTH];

    logic        wen;
    logic        can_send;
    logic        last;
    logic        rd_fc;
    logic        streams;
    logic [3:0]  hlen;
    logic [7:0]  hbyte;
    logic [7:0]  rd_count;
    logic [8:0]  apos;
    logic [8:0]  wpos;
    logic [15:0] item_addr;
    logic [15:0] item_wdata;
    logic [15:0] fill_word;

    // Request bytes as received: unit, function, then the function's fields
    logic [7:0]  b_unit;
    logic [7:0]  b_fc;
    logic [7:0]  b_bc;
    logic [15:0] b_q16;
    assign b_unit = buf_q[0];
    assign b_fc   = buf_q[1];
    assign b_bc   = buf_q[6];
    assign b_q16  = {buf_q[4], buf_q[5]};

    assign wen      = (s.state == mbs_pkg::ST_RX) && i_rx_valid && (s.len < 9'(BUF_DEPTH));
    assign can_send = !s.tx.valid || i_tx_ready;
    assign last     = (s.idx == s.qty - 11'h001);
    assign rd_fc    = s.bits || s.fc == mbs_pkg::FC_RD_HOLD || s.fc == mbs_pkg::FC_RD_INP
                      || s.fc == mbs_pkg::FC_RD_SCAT;
    assign streams  = rd_fc && (s.exc == 8'h00);
    assign rd_count = s.bits ? 8'((s.qty + 11'h007) >> 3) : {s.qty[6:0], 1'b0};
    assign apos     = 9'h003 + {s.idx[7:0], 1'b0};
    assign wpos     = (s.fc == mbs_pkg::FC_WR_REG) ? 9'h004 : 9'h007 + {s.idx[7:0], 1'b0};
    assign item_addr  = (s.fc == mbs_pkg::FC_RD_SCAT) ? {buf_q[AW'(apos)], buf_q[AW'(apos + 9'h001)]}
                                                      : s.addr + 16'(s.idx);
    assign item_wdata = {buf_q[AW'(wpos)], buf_q[AW'(wpos + 9'h001)]};

    always_ff @(posedge i_clk) begin
        if (wen) begin
            buf_q[s.len[AW-1:0]] <= i_rx_data;
        end
    end

    mbs_fill u_fill (
        .i_rsp  (i_map),
        .o_word (fill_word)
    );

    mbs_word_order u_word_order (
        .i_clk       (i_clk),
        .i_rstn      (i_rstn),
        .i_valid     (i_cli_valid),
        .i_first     (i_cli_first),
        .i_second    (i_cli_second),
        .i_low_first (i_cli_low_first),
        .o_valid     (o_cli_valid),
        .o_value     (o_cli_value)
    );

    // Reply header bytes; write replies echo address and quantity, or address and value for FC_WR_REG
    always_comb begin
        hlen  = 4'h3;
        hbyte = 8'h00;
        if (s.exc != 8'h00) begin
            hlen = 4'h3;
        end else if (s.wr) begin
            hlen = 4'h6;
        end else if (s.fc == mbs_pkg::FC_REPORT_ID) begin
            hlen = 4'h5;
        end else if (s.fc == mbs_pkg::FC_DEV_ID) begin
            hlen = 4'hB;
        end
        if (s.hidx == 4'h0) begin
            hbyte = buf_q[0];
        end else if (s.hidx == 4'h1) begin
            hbyte = (s.exc != 8'h00) ? (s.fc | mbs_pkg::EXC_FLAG) : s.fc;
        end else if (s.exc != 8'h00) begin
            hbyte = s.exc;
        end else if (s.wr) begin
            hbyte = buf_q[AW'(s.hidx)];
        end else if (s.fc == mbs_pkg::FC_REPORT_ID) begin
            case (s.hidx)
                4'h2:    hbyte = 8'h02;
                4'h3:    hbyte = SERVER_ID;
                default: hbyte = mbs_pkg::RUN_ON;
            endcase
        end else if (s.fc == mbs_pkg::FC_DEV_ID) begin
            // One object in basic conformity, no more to follow
            case (s.hidx)
                4'h2:    hbyte = mbs_pkg::MEI_DEV_ID;
                4'h3:    hbyte = buf_q[3];
                4'h4:    hbyte = mbs_pkg::DEVID_CONFORM;
                4'h7:    hbyte = 8'h01;
                4'h9:    hbyte = 8'h01;
                4'hA:    hbyte = DEVID_VALUE;
                default: hbyte = 8'h00;
            endcase
        end else begin
            hbyte = rd_count;
        end
    end

    always_comb begin
        logic        for_me;
        logic        known;
        logic [10:0] q;
        logic [10:0] lim;
        logic [8:0]  need;
        logic [7:0]  acc_n;
        for_me = 1'b0;
        known  = 1'b0;
        q      = 11'h000;
        lim    = 11'h000;
        need   = 9'h000;
        acc_n  = 8'h00;
        n      = s;
        n.map.req = 1'b0;
        if (s.tx.valid && i_tx_ready) begin
            n.tx.valid = 1'b0;
        end
        if (s.lo_pend && can_send) begin
            n.tx.valid = 1'b1;
            n.tx.data  = s.lo_byte;
            n.tx.last  = s.lo_last;
            n.lo_pend  = 1'b0;
        end
        case (s.state)
            mbs_pkg::ST_RX: begin
                if (i_rx_valid) begin
                    if (s.len < 9'(BUF_DEPTH)) begin
                        n.len = s.len + 9'h001;
                    end else begin
                        n.ovf = 1'b1;
                    end
                    if (i_rx_last) begin
                        n.state = mbs_pkg::ST_DEC;
                    end
                end
            end
            mbs_pkg::ST_DEC: begin
                n.bcast = (b_unit == mbs_pkg::UNIT_BCAST);
                for_me  = n.bcast || b_unit == i_unit_id
                          || (i_serial && i_single_server && b_unit == mbs_pkg::UNIT_SINGLE);
                n.fc    = b_fc;
                n.addr  = {buf_q[2], buf_q[3]};
                n.exc   = 8'h00;
                n.idx   = 11'h000;
                n.hidx  = 4'h0;
                n.acc   = 8'h00;
                n.bits  = (b_fc == mbs_pkg::FC_RD_COIL) || (b_fc == mbs_pkg::FC_RD_DISC);
                n.wr    = (b_fc == mbs_pkg::FC_WR_REG) || (b_fc == mbs_pkg::FC_WR_REGS);
                n.cls   = (b_fc == mbs_pkg::FC_RD_COIL) ? mbs_pkg::CLS_COIL
                        : (b_fc == mbs_pkg::FC_RD_DISC) ? mbs_pkg::CLS_DISC
                        : (b_fc == mbs_pkg::FC_RD_INP)  ? mbs_pkg::CLS_INP : mbs_pkg::CLS_HOLD;
                known   = b_fc == mbs_pkg::FC_RD_COIL || b_fc == mbs_pkg::FC_RD_DISC
                          || b_fc == mbs_pkg::FC_RD_HOLD || b_fc == mbs_pkg::FC_RD_INP
                          || n.wr || b_fc == mbs_pkg::FC_RD_SCAT
                          || (b_fc == mbs_pkg::FC_REPORT_ID && i_serial)
                          || (b_fc == mbs_pkg::FC_DEV_ID && buf_q[2] == mbs_pkg::MEI_DEV_ID);
                q    = (b_q16[15:11] != 5'h00) ? 11'h7FF : b_q16[10:0];
                lim  = n.bits ? mbs_pkg::MAX_BITS : mbs_pkg::MAX_RD_REGS;
                need = 9'h006;
                if (b_fc == mbs_pkg::FC_WR_REG) begin
                    q = 11'h001;
                end else if (b_fc == mbs_pkg::FC_WR_REGS) begin
                    lim  = mbs_pkg::MAX_WR_REGS;
                    need = 9'h007 + {1'b0, b_bc};
                    if ({3'h0, b_bc} != {q[9:0], 1'b0}) begin
                        q = 11'h000;
                    end
                end else if (b_fc == mbs_pkg::FC_RD_SCAT) begin
                    q    = {4'h0, buf_q[2][7:1]};
                    need = 9'h003 + {1'b0, buf_q[2]};
                end else if (b_fc == mbs_pkg::FC_REPORT_ID || b_fc == mbs_pkg::FC_DEV_ID) begin
                    q    = 11'h001;
                    need = 9'h002;
                end
                n.qty = q;
                if (s.ovf || s.len < 9'h002 || !for_me) begin
                    n.state = mbs_pkg::ST_RX;
                end else if (n.bcast && b_fc != mbs_pkg::FC_WR_REGS) begin
                    n.state = mbs_pkg::ST_RX;
                end else if (!known) begin
                    n.exc   = mbs_pkg::EXC_FUNC;
                    n.state = mbs_pkg::ST_HDR;
                end else if (q == 11'h000 || q > lim || s.len < need) begin
                    n.exc   = mbs_pkg::EXC_VALUE;
                    n.state = n.bcast ? mbs_pkg::ST_RX : mbs_pkg::ST_HDR;
                end else if (b_fc == mbs_pkg::FC_REPORT_ID || b_fc == mbs_pkg::FC_DEV_ID) begin
                    n.state = mbs_pkg::ST_HDR;
                end else begin
                    n.state = mbs_pkg::ST_CHECK;
                end
            end
            mbs_pkg::ST_CHECK: begin
                // Every item is vetted before any store, so a refused write leaves no partial update
                if (!s.pend) begin
                    n.map.req   = 1'b1;
                    n.map.op    = mbs_pkg::OP_PROBE;
                    n.map.cls   = s.cls;
                    n.map.addr  = item_addr;
                    n.map.wdata = item_wdata;
                    n.pend      = 1'b1;
                end else if (i_map.ack) begin
                    n.pend = 1'b0;
                    if (s.wr && !i_map.mapped) begin
                        n.state = mbs_pkg::ST_RX;
                    end else if (!i_map.addr_ok || i_map.secured) begin
                        n.exc = mbs_pkg::EXC_ADDR;
                    end else if (s.wr && i_map.read_only) begin
                        n.exc = mbs_pkg::EXC_VALUE;
                    end else if (i_map.partial) begin
                        n.exc = mbs_pkg::EXC_VALUE;
                    end else if (s.wr && !i_map.value_ok) begin
                        n.exc = mbs_pkg::EXC_VALUE;
                    end else if (last) begin
                        n.idx   = 11'h000;
                        n.state = s.wr ? mbs_pkg::ST_EXEC : mbs_pkg::ST_HDR;
                    end else begin
                        n.idx = s.idx + 11'h001;
                    end
                    if (n.exc != 8'h00) begin
                        n.state = s.bcast ? mbs_pkg::ST_RX : mbs_pkg::ST_HDR;
                    end
                end
            end
            mbs_pkg::ST_HDR: begin
                if (can_send) begin
                    n.tx.valid = 1'b1;
                    n.tx.data  = hbyte;
                    n.tx.last  = (s.hidx == hlen - 4'h1) && !streams;
                    n.hidx     = s.hidx + 4'h1;
                    if (s.hidx == hlen - 4'h1) begin
                        n.state = streams ? mbs_pkg::ST_EXEC : mbs_pkg::ST_FLUSH;
                    end
                end
            end
            mbs_pkg::ST_EXEC: begin
                if (!s.pend && (s.wr || (!s.tx.valid && !s.lo_pend))) begin
                    n.map.req   = 1'b1;
                    n.map.op    = s.wr ? mbs_pkg::OP_WRITE : mbs_pkg::OP_READ;
                    n.map.cls   = s.cls;
                    n.map.addr  = item_addr;
                    n.map.wdata = item_wdata;
                    n.pend      = 1'b1;
                end else if (s.pend && i_map.ack) begin
                    n.pend = 1'b0;
                    n.idx  = s.idx + 11'h001;
                    if (s.wr) begin
                        n.hidx = 4'h0;
                    end else if (s.bits) begin
                        acc_n = s.acc | (8'(fill_word[0]) << s.idx[2:0]);
                        n.acc = acc_n;
                        if (s.idx[2:0] == 3'h7 || last) begin
                            n.tx.valid = 1'b1;
                            n.tx.data  = acc_n;
                            n.tx.last  = last;
                            n.acc      = 8'h00;
                        end
                    end else begin
                        n.tx.valid = 1'b1;
                        n.tx.data  = fill_word[15:8];
                        n.tx.last  = 1'b0;
                        n.lo_pend  = 1'b1;
                        n.lo_byte  = fill_word[7:0];
                        n.lo_last  = last;
                    end
                    if (last) begin
                        n.state = !s.wr ? mbs_pkg::ST_FLUSH
                                : s.bcast ? mbs_pkg::ST_RX : mbs_pkg::ST_HDR;
                    end
                end
            end
            mbs_pkg::ST_FLUSH: begin
                if (!s.tx.valid && !s.lo_pend) begin
                    n.state = mbs_pkg::ST_RX;
                end
            end
            default: begin
                n.state = mbs_pkg::ST_RX;
            end
        endcase
        if (n.state == mbs_pkg::ST_RX && s.state != mbs_pkg::ST_RX) begin
            n.len = 9'h000;
            n.ovf = 1'b0;
        end
        n.rdy = (n.state == mbs_pkg::ST_RX);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign o_rx_ready = s.rdy;
    assign o_map      = s.map;
    assign o_tx       = s.tx;
endmodule : mbs_server
`default_nettype wire

// ### src/mbs_word_order.sv
// Client side assembly of a 32-bit float from two received words in either order
`timescale 1ns/100ps
`default_nettype none
module mbs_word_order (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_valid,
    input  wire logic [15:0] i_first,
    input  wire logic [15:0] i_second,
    input  wire logic        i_low_first,
    output logic             o_valid,
    output logic [31:0]      o_value
);
    typedef struct packed {
        logic        valid;
        logic [31:0] value;
    } mbs_wo_st_t;

    mbs_wo_st_t s;
    mbs_wo_st_t n;

    always_comb begin
        n.valid = i_valid;
        n.value = s.value;
        if (i_valid) begin
            n.value = i_low_first ? {i_second, i_first} : {i_first, i_second};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign o_valid = s.valid;
    assign o_value = s.value;
endmodule : mbs_word_order
`default_nettype wire

// ### tb/mbs_map_model.sv
// Register map responder: addr[15:12]=F unmapped, 1 illegal, bit13 reserved float, bit14 read-only
`timescale 1ns/100ps
`default_nettype none
module mbs_map_model (
    input  wire logic                  i_clk,
    input  wire logic                  i_rstn,
    input  wire mbs_pkg::mbs_map_req_t i_req,
    output mbs_pkg::mbs_map_rsp_t      o_rsp = '0
);
    int   wait_cnt = 0;
    logic pend = 1'h0;
    always @(posedge i_clk) begin
        o_rsp.ack <= 1'h0;
        o_rsp.rdata <= ~o_rsp.rdata; // Data is only good in the ack cycle
        if (!i_rstn) pend <= 1'h0;
        else if (i_req.req) begin
            pend <= 1'h1;
            wait_cnt <= $urandom_range(0, 3);
        end else if (pend && wait_cnt == 0) begin
            pend <= 1'h0;
            o_rsp <= '{1'h1, i_req.addr[15:12] != 4'hF, i_req.addr[13], i_req.addr[15:12] != 4'h1, 1'h0,
                i_req.addr[14], 1'h0, 1'h1, i_req.addr[13] ? mbs_pkg::FMT_F32 : mbs_pkg::FMT_U16, 2'h0,
                i_req.addr ^ 16'h5A3C};
        end else if (pend) wait_cnt <= wait_cnt - 1;
    end
endmodule : mbs_map_model
`default_nettype wire

// ### tb/mbs_server_assertions.sv
// Port checks on the request handler
`timescale 1ns/100ps
`default_nettype none
module mbs_server_assertions (
    input wire logic                  i_clk,
    input wire logic                  i_rstn,
    input wire logic                  i_rx_valid,
    input wire logic [7:0]            i_rx_data,
    input wire logic                  i_rx_last,
    input wire logic                  o_rx_ready,
    input wire mbs_pkg::mbs_map_req_t o_map,
    input wire mbs_pkg::mbs_byte_t    o_tx,
    input wire logic                  i_tx_ready,
    input wire logic                  i_cli_valid,
    input wire logic [15:0]           i_cli_first,
    input wire logic [15:0]           i_cli_second,
    input wire logic                  i_cli_low_first,
    input wire logic                  o_cli_valid,
    input wire logic [31:0]           o_cli_value
);
    logic in_frame;
    logic bcast;
    // Unit byte is only the first byte of a frame, payload zeros must not count
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            in_frame <= 1'h0;
            bcast    <= 1'h0;
        end else if (o_rx_ready && i_rx_valid) begin
            in_frame <= !i_rx_last;
            if (!in_frame) bcast <= i_rx_data == mbs_pkg::UNIT_BCAST;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    AST_BCAST_SILENT: assert property (o_tx.valid |-> !bcast) else $error("reply to broadcast");
    AST_TX_HOLD: assert property (o_tx.valid && !i_tx_ready |=> o_tx.valid && $stable(o_tx)) else $error("tx dropped");
    AST_REQ_PULSE: assert property (o_map.req |=> !o_map.req) else $error("map req too long");
    AST_REQ_STAND: assert property (o_map.req |=> $stable(o_map.addr) && $stable(o_map.op)) else $error("map moved");
    AST_RX_CLOSE: assert property (o_rx_ready && i_rx_valid && i_rx_last |=> ##[0:1] !o_rx_ready) else $error("rdy");
    AST_TX_QUIET: assert property (o_rx_ready |-> !o_tx.valid) else $error("tx while receiving");
    AST_CLI_HI: assert property (i_cli_valid && !i_cli_low_first |=> o_cli_valid
        && o_cli_value == {$past(i_cli_first), $past(i_cli_second)}) else $error("upper-first float wrong");
    AST_CLI_LO: assert property (i_cli_valid && i_cli_low_first |=> o_cli_valid
        && o_cli_value == {$past(i_cli_second), $past(i_cli_first)}) else $error("lower-first float wrong");
endmodule : mbs_server_assertions
bind mbs_server mbs_server_assertions mbs_server_assertions_inst (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .i_rx_last(i_rx_last), .o_rx_ready(o_rx_ready),
    .o_map(o_map), .o_tx(o_tx), .i_tx_ready(i_tx_ready), .i_cli_valid(i_cli_valid), .i_cli_first(i_cli_first),
    .i_cli_second(i_cli_second), .i_cli_low_first(i_cli_low_first), .o_cli_valid(o_cli_valid),
    .o_cli_value(o_cli_value));
`default_nettype wire

// ### tb/mbs_server_tb_top.sv
// Self-checking bench for the request handler
`timescale 1ns/100ps
`default_nettype none
module mbs_server_tb_top;
    localparam logic [7:0] U = 8'h21;
    localparam logic [7:0] SID = 8'h33; // Arbitrary identity value
    logic i_clk = 1'h0, i_rstn = 1'h0, serial = 1'h1, single = 1'h0, rx_valid = 1'h0, rx_last = 1'h0, rx_ready;
    logic tx_ready = 1'h0, cli_valid = 1'h0, cli_low = 1'h0;
    logic [7:0] rx_data = 8'h00;
    logic [31:0] cli_w = 32'h0;
    logic [15:0] v;
    logic [8:0] expq[$];
    int mismatches = 0, n_compared = 0, cycles = 0;
    mbs_pkg::mbs_map_req_t map_req;
    mbs_pkg::mbs_map_rsp_t map_rsp;
    mbs_pkg::mbs_byte_t tx;
    always #5 i_clk = ~i_clk;
    mbs_server #(.SERVER_ID(SID), .DEVID_VALUE(SID)) mbs_server_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_unit_id(U),
        .i_serial(serial), .i_single_server(single), .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_last(rx_last),
        .o_rx_ready(rx_ready), .o_map(map_req), .i_map(map_rsp), .o_tx(tx), .i_tx_ready(tx_ready),
        .i_cli_valid(cli_valid), .i_cli_first(cli_w[31:16]), .i_cli_second(cli_w[15:0]),
        .i_cli_low_first(cli_low), .o_cli_valid(), .o_cli_value());
    mbs_map_model mbs_map_model_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(map_req), .o_rsp(map_rsp));
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    task automatic ex(input logic [7:0] b[$]);
        foreach (b[i]) expq.push_back({i == b.size() - 1, b[i]});
    endtask : ex
    task automatic send(input logic [7:0] f[$]);
        int k;
        k = 0;
        foreach (f[i]) begin
            rx_valid = 1'h1;
            rx_data = f[i];
            rx_last = i == f.size() - 1;
            @(negedge i_clk);
        end
        rx_valid = 1'h0;
        rx_last = 1'h0;
        repeat (2) @(negedge i_clk);
        while (!rx_ready && k < 300) begin
            @(negedge i_clk);
            k++;
        end
        if (k == 300) mismatches++;
    endtask : send
    task automatic req(input logic [7:0] u, fc, input logic [15:0] ad, val);
        if (fc == 8'h10) send('{u, fc, ad[15:8], ad[7:0], 8'h00, 8'h01, 8'h02, val[15:8], val[7:0]});
        else send('{u, fc, ad[15:8], ad[7:0], val[15:8], val[7:0]});
    endtask : req
    // Sink stalls at random so reply bytes see back-pressure at random
    always @(negedge i_clk) tx_ready <= 1'($urandom_range(0, 1));
    always @(posedge i_clk) begin
        if (tx.valid === 1'h1 && tx_ready) begin
            n_compared++;
            if (expq.size() == 0 || expq[0] !== {tx.last, tx.data}) begin
                mismatches++;
                $display("[FAIL] t=%0t want=%h got=%h", $time, expq.size() ? expq[0] : 9'h0, {tx.last, tx.data});
            end
            if (expq.size()) void'(expq.pop_front());
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(67));
        repeat (20) @(negedge i_clk);
        i_rstn = 1'h1;
        repeat (3) @(negedge i_clk);
        for (int f = 3; f < 5; f++) begin
            v = 16'($urandom_range(0, 4095));
            ex('{U, 8'(f), 8'h02, v[15:8] ^ 8'h5A, v[7:0] ^ 8'h3C});
            req(U, 8'(f), v, 16'h0001);
        end
        ex('{U, 8'h03, 8'h02, 8'h80, 8'h00});
        req(U, 8'h03, 16'hF000, 16'h0001);
        ex('{U, 8'h03, 8'h02, 8'hFF, 8'hC0});
        req(U, 8'h03, 16'h2000, 16'h0001);
        ex('{U, 8'h01, 8'h01, 8'h02});
        req(U, 8'h01, 16'h0030, 16'h0003);
        ex('{U, 8'h83, 8'h02});
        req(U, 8'h03, 16'h1000, 16'h0001);
        v = 16'($urandom());
        ex('{U, 8'h06, 8'h00, 8'h20, v[15:8], v[7:0]});
        req(U, 8'h06, 16'h0020, v);
        ex('{U, 8'h86, 8'h03});
        req(U, 8'h06, 16'h4020, v);
        req(U, 8'h06, 16'hF010, v);
        for (int i = 0; i < 3; i++) begin
            ex('{U, 8'h80 | 8'(i * 5 + 5), 8'h01});
            req(U, 8'(i * 5 + 5), 16'h0000, 16'h0001);
        end
        req(8'h00, 8'h10, 16'h0030, v);
        req(8'h00, 8'h03, 16'h0030, 16'h0001);
        single = 1'h1;
        ex('{8'hF8, 8'h03, 8'h02, 8'h5A, 8'h0C});
        req(8'hF8, 8'h03, 16'h0030, 16'h0001);
        single = 1'h0;
        req(8'hF8, 8'h03, 16'h0030, 16'h0001);
        ex('{U, 8'h11, 8'h02, SID, 8'hFF});
        send('{U, 8'h11});
        serial = 1'h0;
        ex('{U, 8'h91, 8'h01});
        send('{U, 8'h11});
        ex('{U, 8'h2B, 8'h0E, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, SID});
        send('{U, 8'h2B, 8'h0E, 8'h01, 8'h00});
        ex('{U, 8'h64, 8'h04, 8'h5A, 8'h0C, 8'hFF, 8'hC0});
        send('{U, 8'h64, 8'h04, 8'h00, 8'h30, 8'h20, 8'h00});
        repeat (6) begin
            cli_w = $urandom();
            cli_low = ~cli_low;
            cli_valid = 1'h1;
            @(negedge i_clk);
            cli_valid = 1'h0;
            @(negedge i_clk);
        end
        if (expq.size()) mismatches++;
        print_verdict();
    end
endmodule : mbs_server_tb_top
`default_nettype wire
